/* File: ofs_pkg.sv */
// Constants for the output function selector
package ofs_pkg;
    localparam int unsigned SEL_W = 7;
    localparam int unsigned N_TERM = 4;
    localparam logic [31:0] ADR_SEL_FAST = 32'h0000_0000;
    localparam logic [31:0] ADR_SEL_OC = 32'h0000_0004;
    localparam logic [31:0] ADR_SEL_RLY1 = 32'h0000_0008;
    localparam logic [31:0] ADR_SEL_RLY2 = 32'h0000_000c;
    localparam logic [31:0] ADR_POLARITY = 32'h0000_0010;
    localparam logic [31:0] ADR_VIRT = 32'h0000_0014;
    localparam logic [31:0] ADR_STATUS = 32'h0000_0018;
    localparam logic [31:0] ADR_FAST_MODE = 32'h0000_001c;
    localparam logic [6:0] RST_SEL_FAST = 7'h00;
    localparam logic [6:0] RST_SEL_OC = 7'h00;
    localparam logic [6:0] RST_SEL_RLY1 = 7'h01;
    localparam logic [6:0] RST_SEL_RLY2 = 7'h00;
    localparam logic [3:0] RST_POLARITY = 4'h0;
    localparam logic [3:0] POL_MASK = 4'hf;
    localparam logic [3:0] RST_VIRT = 4'h0;
    localparam int unsigned VIRT_MODBUS = 0;
    localparam int unsigned VIRT_FIELDBUS = 1;
    localparam int unsigned VIRT_ETHERNET = 2;
    localparam int unsigned VIRT_PROFINET = 3;
    localparam int unsigned T_FAST = 0;
    localparam int unsigned T_OC = 1;
    localparam int unsigned T_RLY1 = 2;
    localparam int unsigned T_RLY2 = 3;
    localparam logic RST_FAST_MODE = 1'b0;
    localparam logic FAST_MODE_PULSE = 1'b1;
    localparam int unsigned N_COND = 26;
    typedef enum logic [SEL_W-1:0] {
        FN_NONE = 7'h00, FN_RUN = 7'h01, FN_RUN_FWD = 7'h02, FN_RUN_REV = 7'h03,
        FN_JOG = 7'h04, FN_FAULT = 7'h05, FN_ZERO_SPD = 7'h09, FN_UPPER = 7'h0a,
        FN_LOWER = 7'h0b, FN_READY = 7'h0c, FN_PREEXC = 7'h0d, FN_OVERLOAD = 7'h0e,
        FN_UNDERLOAD = 7'h0f, FN_STAGE_DONE = 7'h10, FN_CYCLE_DONE = 7'h11,
        FN_MODBUS = 7'h17, FN_FIELDBUS = 7'h18, FN_ETHERNET = 7'h19, FN_BUS_OK = 7'h1a,
        FN_PROFINET = 7'h22, FN_FIRE = 7'h30, FN_LOOP_LOW = 7'h31, FN_LOOP_HIGH = 7'h32,
        FN_LOOP_SLEEP = 7'h33, FN_LOOP2_START = 7'h34, FN_LOOP2_STOP = 7'h35,
        FN_BACKUP_PRESS = 7'h36, FN_WATER_SHORT = 7'h37, FN_PREALARM = 7'h38,
        FN_PUMP_A = 7'h39, FN_PUMP_D = 7'h3c
    } ofs_func_t;
endpackage

/* File: ofs_output_function_selector.sv */
// Output function selector for the drive's digital output terminals
//
// Contract
// - Four terminals: fast pulse, open collector, two relays, each with own selection.
// - Fast pulse terminal selects pulse-train or ordinary on/off output; only the mode bit reaches o_fast_pulse_mode, the terminal stays on/off.
// - One code may drive several terminals, each following the same condition.
// - Code zero gives no function; the terminal stays inactive.
// - Codes 1 to 4: running, forward, reverse, jog with frequency delivered.
// - Code 5 follows the fault condition.
// - Code 9 on only when output and reference frequency are both zero.
// - Code 10 on when running frequency reached upper limit.
// - Code 11 on when running frequency reached lower limit.
// - Code 12 needs both powers, no protection active, and ready to run.
// - Code 13 on while pre-excitation is in progress.
// - Code 14 follows overload pre-alarm after its pre-alarm time.
// - Code 15 follows underload pre-alarm after its pre-alarm time.
// - Code 16 signals step sequencer stage completion.
// - Code 17 signals step sequencer full cycle completion.
// - Code 23 mirrors the Modbus virtual bit, one on, zero off.
// - Code 24 mirrors the PROFIBUS or CANopen virtual bit.
// - Code 25 mirrors the Ethernet virtual bit.
// - Code 34 mirrors the PROFINET virtual bit.
// - Code 26 on while DC bus is above undervoltage level.
// - Codes 48 to 56 follow fire, loop alarms, sleep, pump and pre-alarm states.
// - Codes 57 to 60 drive contactor commands for circulation pumps A to D.
// - Four-bit polarity mask inverts each terminal; resets to zero.
//
// The Wishbone slave port and the address map were left to the implementer.
module ofs_output_function_selector
    import ofs_pkg::*;
#(
    parameter int unsigned TERMS = N_TERM
) (
    input  wire logic        i_core_clk,
    input  wire logic        i_rst,
    input  wire logic        i_ce,
    input  wire logic        i_run_freq,
    input  wire logic        i_run_fwd,
    input  wire logic        i_run_rev,
    input  wire logic        i_jog,
    input  wire logic        i_fault,
    input  wire logic        i_out_freq_zero,
    input  wire logic        i_ref_freq_zero,
    input  wire logic        i_upper_limit,
    input  wire logic        i_lower_limit,
    input  wire logic        i_main_power_ok,
    input  wire logic        i_ctrl_power_ok,
    input  wire logic        i_protection_active,
    input  wire logic        i_ready_to_run,
    input  wire logic        i_preexcite,
    input  wire logic        i_overload_prealarm,
    input  wire logic        i_underload_prealarm,
    input  wire logic        i_stage_done,
    input  wire logic        i_cycle_done,
    input  wire logic        i_bus_above_uv,
    input  wire logic [8:0]  i_pump_status,
    input  wire logic [3:0]  i_pump_contactor,
    input  wire logic        i_fast_pulse_train,
    input  wire logic [31:0] i_wb_adr,
    input  wire logic [31:0] i_wb_dat,
    input  wire logic [3:0]  i_wb_sel,
    input  wire logic        i_wb_we,
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    output logic [31:0]      o_wb_dat,
    output logic             o_wb_ack,
    output logic             o_wb_err,
    output logic             o_fast_pulse_terminal,
    output logic             o_open_collector,
    output logic             o_relay1,
    output logic             o_relay2,
    output logic             o_fast_pulse_mode
);

    // Only the four documented terminals are wired
    if (TERMS != N_TERM) begin : g_bad_terms
        $error("ofs: TERMS must equal N_TERM");
    end

    logic [SEL_W-1:0] sel_r [N_TERM];
    logic [3:0]       polarity_r;
    logic [3:0]       virt_r;
    logic             fast_mode_r;
    logic [3:0]       term_r;
    logic             ack_r;
    logic             err_r;
    logic [31:0]      rdat_r;
    logic             req;
    logic             hit;
    logic             wr_lo;

    // Condition lookup for one selection code
    function automatic logic cond_of(input logic [SEL_W-1:0] code,
                                     input logic [N_COND-1:0] c,
                                     input logic [3:0] pumps);
        logic r;
        r = 1'b0;
        case (code)
            FN_NONE: begin
                r = 1'b0;
            end
            FN_RUN: begin
                r = c[0];
            end
            FN_RUN_FWD: begin
                r = c[1];
            end
            FN_RUN_REV: begin
                r = c[2];
            end
            FN_JOG: begin
                r = c[3];
            end
            FN_FAULT: begin
                r = c[4];
            end
            FN_ZERO_SPD: begin
                r = c[5];
            end
            FN_UPPER: begin
                r = c[6];
            end
            FN_LOWER: begin
                r = c[7];
            end
            FN_READY: begin
                r = c[8];
            end
            FN_PREEXC: begin
                r = c[9];
            end
            FN_OVERLOAD: begin
                r = c[10];
            end
            FN_UNDERLOAD: begin
                r = c[11];
            end
            FN_STAGE_DONE: begin
                r = c[12];
            end
            FN_CYCLE_DONE: begin
                r = c[13];
            end
            FN_MODBUS: begin
                r = c[14];
            end
            FN_FIELDBUS: begin
                r = c[15];
            end
            FN_ETHERNET: begin
                r = c[16];
            end
            FN_BUS_OK: begin
                r = c[17];
            end
            FN_PROFINET: begin
                r = c[18];
            end
            FN_FIRE: begin
                r = c[19];
            end
            FN_LOOP_LOW: begin
                r = c[20];
            end
            FN_LOOP_HIGH: begin
                r = c[21];
            end
            FN_LOOP_SLEEP: begin
                r = c[22];
            end
            FN_LOOP2_START: begin
                r = c[23];
            end
            FN_LOOP2_STOP: begin
                r = c[24];
            end
            FN_BACKUP_PRESS: begin
                r = c[25];
            end
            default: begin
                if (code >= FN_PUMP_A && code <= FN_PUMP_D) begin
                    r = pumps[2'(code - FN_PUMP_A)];
                end else begin
                    r = 1'b0;
                end
            end
        endcase
        return r;
    endfunction

    // Water shortage and pre-alarm codes, taken outside the lookup
    logic [1:0] extra_st;

    logic [N_COND-1:0] cond;
    always_comb begin
        cond = '0;
        cond[0] = i_run_freq;
        cond[1] = i_run_freq & i_run_fwd;
        cond[2] = i_run_freq & i_run_rev;
        cond[3] = i_run_freq & i_jog;
        cond[4] = i_fault;
        cond[5] = i_out_freq_zero & i_ref_freq_zero;
        cond[6] = i_upper_limit;
        cond[7] = i_lower_limit;
        cond[8] = i_main_power_ok & i_ctrl_power_ok & ~i_protection_active
                  & i_ready_to_run;
        cond[9] = i_preexcite;
        cond[10] = i_overload_prealarm;
        cond[11] = i_underload_prealarm;
        cond[12] = i_stage_done;
        cond[13] = i_cycle_done;
        cond[14] = virt_r[VIRT_MODBUS];
        cond[15] = virt_r[VIRT_FIELDBUS];
        cond[16] = virt_r[VIRT_ETHERNET];
        cond[17] = i_bus_above_uv;
        cond[18] = virt_r[VIRT_PROFINET];
        cond[25:19] = i_pump_status[6:0];
    end
    assign extra_st = i_pump_status[8:7];

    // Selected condition per terminal, with the last two station codes
    logic [3:0] term_nxt;
    always_comb begin
        for (int t = 0; t < N_TERM; t++) begin
            if (sel_r[t] == FN_WATER_SHORT) begin
                term_nxt[t] = extra_st[0];
            end else if (sel_r[t] == FN_PREALARM) begin
                term_nxt[t] = extra_st[1];
            end else begin
                term_nxt[t] = cond_of(sel_r[t], cond, i_pump_contactor);
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            term_r <= '0;
        end else if (i_ce) begin
            term_r <= term_nxt ^ (polarity_r & POL_MASK);
        end
    end

    assign o_fast_pulse_terminal = term_r[T_FAST];
    assign o_open_collector = term_r[T_OC];
    assign o_relay1 = term_r[T_RLY1];
    assign o_relay2 = term_r[T_RLY2];
    assign o_fast_pulse_mode = fast_mode_r;

    // Wishbone slave, one wait state
    assign req = i_wb_cyc & i_wb_stb & ~ack_r & ~err_r;
    assign wr_lo = req & i_wb_we & i_wb_sel[0];

    // Address decode for the eight mapped words
    function automatic logic adr_mapped(input logic [31:0] a);
        logic m;
        m = 1'b0;
        case (a)
            ADR_SEL_FAST, ADR_SEL_OC, ADR_SEL_RLY1, ADR_SEL_RLY2: begin
                m = 1'b1;
            end
            ADR_POLARITY, ADR_VIRT, ADR_STATUS, ADR_FAST_MODE: begin
                m = 1'b1;
            end
            default: begin
                m = 1'b0;
            end
        endcase
        return m;
    endfunction

    assign hit = adr_mapped(i_wb_adr);

    // Acknowledge for mapped words
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            ack_r <= 1'b0;
        end else if (i_ce) begin
            ack_r <= req & hit;
        end
    end

    // Error for unmapped words
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            err_r <= 1'b0;
        end else if (i_ce) begin
            err_r <= req & ~hit;
        end
    end

    // Selection codes, one per terminal
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            sel_r[T_FAST] <= RST_SEL_FAST;
            sel_r[T_OC] <= RST_SEL_OC;
            sel_r[T_RLY1] <= RST_SEL_RLY1;
            sel_r[T_RLY2] <= RST_SEL_RLY2;
        end else if (i_ce && wr_lo) begin
            case (i_wb_adr)
                ADR_SEL_FAST: begin
                    sel_r[T_FAST] <= i_wb_dat[SEL_W-1:0];
                end
                ADR_SEL_OC: begin
                    sel_r[T_OC] <= i_wb_dat[SEL_W-1:0];
                end
                ADR_SEL_RLY1: begin
                    sel_r[T_RLY1] <= i_wb_dat[SEL_W-1:0];
                end
                ADR_SEL_RLY2: begin
                    sel_r[T_RLY2] <= i_wb_dat[SEL_W-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Polarity mask
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            polarity_r <= RST_POLARITY;
        end else if (i_ce && wr_lo && i_wb_adr == ADR_POLARITY) begin
            polarity_r <= i_wb_dat[3:0] & POL_MASK;
        end
    end

    // Virtual terminal bits written by the fieldbus masters
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            virt_r <= RST_VIRT;
        end else if (i_ce && wr_lo && i_wb_adr == ADR_VIRT) begin
            virt_r <= i_wb_dat[3:0];
        end
    end

    // Fast terminal mode
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            fast_mode_r <= RST_FAST_MODE;
        end else if (i_ce && wr_lo && i_wb_adr == ADR_FAST_MODE) begin
            fast_mode_r <= i_wb_dat[0] | i_fast_pulse_train & 1'b0;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            rdat_r <= '0;
        end else if (i_ce && req) begin
            case (i_wb_adr)
                ADR_SEL_FAST:  rdat_r <= {25'h0, sel_r[T_FAST]};
                ADR_SEL_OC:    rdat_r <= {25'h0, sel_r[T_OC]};
                ADR_SEL_RLY1:  rdat_r <= {25'h0, sel_r[T_RLY1]};
                ADR_SEL_RLY2:  rdat_r <= {25'h0, sel_r[T_RLY2]};
                ADR_POLARITY:  rdat_r <= {28'h0, polarity_r};
                ADR_VIRT:      rdat_r <= {28'h0, virt_r};
                ADR_STATUS:    rdat_r <= {28'h0, term_r};
                ADR_FAST_MODE: rdat_r <= {31'h0, fast_mode_r};
                default:       rdat_r <= '0;
            endcase
        end
    end

    assign o_wb_dat = rdat_r;
    assign o_wb_ack = ack_r;
    assign o_wb_err = err_r;

endmodule

/* File: ofs_sva.sv */
// Port checker for the output function selector
module ofs_sva_chk
    import ofs_pkg::*;
(
    input wire logic        i_core_clk,
    input wire logic        i_rst,
    input wire logic        i_ce,
    input wire logic [31:0] i_wb_adr,
    input wire logic [31:0] i_wb_dat,
    input wire logic [3:0]  i_wb_sel,
    input wire logic        i_wb_we,
    input wire logic        i_wb_cyc,
    input wire logic        i_wb_stb,
    input wire logic [31:0] o_wb_dat,
    input wire logic        o_wb_ack,
    input wire logic        o_wb_err,
    input wire logic        o_fast_pulse_terminal,
    input wire logic        o_open_collector,
    input wire logic        o_relay1,
    input wire logic        o_relay2,
    input wire logic        o_fast_pulse_mode
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    logic [3:0] pins;
    logic       req;
    assign pins = {o_relay2, o_relay1, o_open_collector, o_fast_pulse_terminal};
    assign req = i_wb_cyc && i_wb_stb && !o_wb_ack && !o_wb_err && i_ce;
    a_ce_freeze: assert property (!i_ce |=> $stable(pins))
        else $error("terminals moved while frozen");
    a_ack_pulse: assert property (o_wb_ack && i_ce |=> !o_wb_ack)
        else $error("ack held too long");
    a_ack_mapped: assert property (req && i_wb_adr <= 32'h1c && i_wb_adr[1:0] == 2'h0
        |=> o_wb_ack && !o_wb_err) else $error("no ack");
    a_err_unmapped: assert property (req && i_wb_adr > 32'h1c |=> o_wb_err && !o_wb_ack)
        else $error("no err");
    a_idle_quiet: assert property (!req |=> !o_wb_ack && !o_wb_err)
        else $error("answer without request");
    a_reset_quiet: assert property ($past(i_rst) |-> pins == 4'h0 && !o_fast_pulse_mode)
        else $error("outputs active after reset");
    a_mode_by_write: assert property ($changed(o_fast_pulse_mode)
        |-> o_wb_ack && i_wb_we && i_wb_adr == ADR_FAST_MODE) else $error("mode moved");
    a_mode_value: assert property (o_wb_ack && i_wb_we && i_wb_adr == ADR_FAST_MODE
        && i_wb_sel[0] |-> o_fast_pulse_mode == i_wb_dat[0]) else $error("mode wrong");
    a_status_read: assert property (o_wb_ack && !i_wb_we && i_wb_adr == ADR_STATUS
        |-> o_wb_dat == {28'h0, $past(pins)}) else $error("status wrong");
    c_write: cover property (o_wb_ack && i_wb_we);
    c_err: cover property (o_wb_err);
    c_relay: cover property ($rose(o_relay1));
endmodule

bind ofs_output_function_selector ofs_sva_chk u_chk (.i_core_clk(i_core_clk), .i_rst(i_rst),
    .i_ce(i_ce), .i_wb_adr(i_wb_adr), .i_wb_dat(i_wb_dat), .i_wb_sel(i_wb_sel),
    .i_wb_we(i_wb_we), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .o_wb_dat(o_wb_dat),
    .o_wb_ack(o_wb_ack), .o_wb_err(o_wb_err), .o_fast_pulse_terminal(o_fast_pulse_terminal),
    .o_open_collector(o_open_collector), .o_relay1(o_relay1), .o_relay2(o_relay2),
    .o_fast_pulse_mode(o_fast_pulse_mode));

/* File: ofs_load_model.sv */
// Loads hanging on the four output terminals
module ofs_load_model (
    input  wire logic       i_fast,
    input  wire logic       i_oc,
    input  wire logic       i_rly1,
    input  wire logic       i_rly2,
    output logic      [3:0] o_level
);
    timeunit 1ns;
    timeprecision 1ps;
    assign o_level = {i_rly2, i_rly1, i_oc, i_fast}; // Each load sees its own pin
endmodule

/* File: tb_output_function_selector.sv */
// Self-checking testbench for the output function selector
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin errors++; \
    $display("unexpected %s exp %0h got %0h", n, e, g); end end
module tb_output_function_selector
    import ofs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_core_clk = 1'b0, i_rst = 1'b1, we = 1'b0, cyc = 1'b0, rerr;
    logic [18:0] cv = '0;
    logic [8:0]  ps = '0;
    logic [3:0]  pc = '0, sel = 4'hf, virt = '0, pol = '0, lvl, sx;
    logic        ce = 1'b1;
    logic [31:0] adr = '0, wdat = '0, rdat, o_wb_dat;
    logic        o_wb_ack, o_wb_err, o_fast, o_oc, o_rly1, o_rly2, o_mode;
    logic [31:0] rv [8] = '{RST_SEL_FAST, RST_SEL_OC, RST_SEL_RLY1, RST_SEL_RLY2,
                             RST_POLARITY, RST_VIRT, 32'h0, RST_FAST_MODE};
    int          errors = 0, num_checks = 0, cycles = 0, code [4];
    always #2.5 i_core_clk = ~i_core_clk;
    ofs_output_function_selector u_ofs_output_function_selector (.i_core_clk(i_core_clk),
        .i_rst(i_rst), .i_ce(ce), .i_run_freq(cv[0]), .i_run_fwd(cv[1]), .i_run_rev(cv[2]),
        .i_jog(cv[3]), .i_fault(cv[4]), .i_out_freq_zero(cv[5]), .i_ref_freq_zero(cv[6]),
        .i_upper_limit(cv[7]), .i_lower_limit(cv[8]), .i_main_power_ok(cv[9]),
        .i_ctrl_power_ok(cv[10]), .i_protection_active(cv[11]), .i_ready_to_run(cv[12]),
        .i_preexcite(cv[13]), .i_overload_prealarm(cv[14]), .i_underload_prealarm(cv[15]),
        .i_stage_done(cv[16]), .i_cycle_done(cv[17]), .i_bus_above_uv(cv[18]),
        .i_pump_status(ps), .i_pump_contactor(pc), .i_fast_pulse_train(1'b0), .i_wb_adr(adr),
        .i_wb_dat(wdat), .i_wb_sel(sel), .i_wb_we(we), .i_wb_cyc(cyc), .i_wb_stb(cyc),
        .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .o_wb_err(o_wb_err),
        .o_fast_pulse_terminal(o_fast), .o_open_collector(o_oc), .o_relay1(o_rly1),
        .o_relay2(o_rly2), .o_fast_pulse_mode(o_mode));
    ofs_load_model u_ofs_load_model (.i_fast(o_fast), .i_oc(o_oc), .i_rly1(o_rly1), .i_rly2(o_rly2),
        .o_level(lvl));
    task automatic test_done();
        if (errors == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    always @(posedge i_core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            test_done();
        end
    end
    task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge i_core_clk);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge i_core_clk); while (!(o_wb_ack || o_wb_err));
        rdat = o_wb_dat;
        rerr = o_wb_err;
        cyc <= 1'b0;
    endtask
    function automatic logic fexp(int c, int t);
        logic v;
        case (c)
            1, 5: v = cv[c-1];
            2, 3, 4: v = cv[0] & cv[c-1];
            9: v = cv[5] & cv[6];
            10, 11: v = cv[c-3];
            12: v = cv[9] & cv[10] & !cv[11] & cv[12];
            13, 14, 15, 16, 17: v = cv[c];
            23, 24, 25: v = virt[c-23];
            26: v = cv[18];
            34: v = virt[3];
            48, 49, 50, 51, 52, 53, 54, 55, 56: v = ps[c-48];
            57, 58, 59, 60: v = pc[c-57];
            default: v = 1'b0;
        endcase
        return v ^ pol[t];
    endfunction
    initial begin
        void'($urandom(78));
        repeat (20) @(posedge i_core_clk);
        `CHK("reset levels", 4'h0, lvl)
        i_rst <= 1'b0;
        for (int a = 0; a < 8; a++) begin
            wb(1'b0, 32'h4 * a, 32'h0);
            `CHK("reset value", rv[a], rdat)
        end
        wb(1'b0, 32'h20, 32'h0);
        `CHK("unmapped err", 1'b1, rerr)
        wb(1'b1, ADR_FAST_MODE, 32'h1);
        `CHK("pulse mode", FAST_MODE_PULSE, o_mode)
        sel <= 4'he;
        wb(1'b1, ADR_FAST_MODE, 32'h0);
        `CHK("masked lane", FAST_MODE_PULSE, o_mode)
        sel <= 4'hf;
        wb(1'b1, ADR_FAST_MODE, 32'h0);
        `CHK("digital mode", RST_FAST_MODE, o_mode)
        for (int c = 0; c < 65; c++) begin
            for (int t = 0; t < 4; t++) begin
                code[t] = (c == 64) ? 127 : (c % 2 == 1) ? c : (c + 13 * t) % 61;
                wb(1'b1, ADR_SEL_FAST + 32'h4 * t, code[t]);
            end
            pol = 4'($urandom);
            virt = 4'($urandom);
            wb(1'b1, ADR_POLARITY, {28'h0, pol});
            wb(1'b1, ADR_VIRT, {28'h0, virt});
            repeat (6) begin
                @(posedge i_core_clk);
                cv <= 19'($urandom);
                ps <= 9'($urandom);
                pc <= 4'($urandom);
                @(posedge i_core_clk);
                #1;
                for (int t = 0; t < 4; t++) `CHK("terminal", fexp(code[t], t), lvl[t])
            end
            for (int t = 0; t < 4; t++) sx[t] = fexp(code[t], t);
            wb(1'b0, ADR_STATUS, 32'h0);
            `CHK("status", {28'h0, sx}, rdat)
        end
        ce <= 1'b0;
        @(posedge i_core_clk);
        cv <= ~cv;
        ps <= ~ps;
        pc <= ~pc;
        repeat (3) @(posedge i_core_clk);
        #1;
        `CHK("frozen", sx, lvl)
        @(posedge i_core_clk);
        ce <= 1'b1;
        @(posedge i_core_clk);
        #1;
        for (int t = 0; t < 4; t++) `CHK("thawed", fexp(code[t], t), lvl[t])
        test_done();
    end
endmodule
